// File: src/tsxe_exec_unit.sv
// Purpose: Decode and execute test-skip, xor, pointer and table write ops
// Assumes: One instruction per four phases; register file answers in Q2
// Notes:   Skips flush the prefetched word with all-idle cycles
//
// Overview of operation
// - Word 0110 011a ffff ffff tests a register and skips; flags untouched.
// - Zero register discards prefetched word, runs idle cycle; two cycles total.
// - One cycle no skip, two skipping, three over a two-word instruction.
// - Bank bit 0 picks access bank; 1 uses bank select register.
// - Extended set, bank bit 0, address up to 5Fh: indexed literal offset.
// - 0000 1010 kkkk kkkk xors literal into accumulator, sets N and Z.
// - 0001 10da ffff ffff xors accumulator with register, sets N and Z.
// - Destination bit 0 writes accumulator, 1 writes back to register.
// - Base set plus optional two literal pointer instructions (add and subtract).
// - Extended ops and indexed offset stay off unless enable bit set.
// - Pointer add/subtract on third pointer with selector 3 also returns from subroutine.
`include "tsxe_map.svh"

module tsxe_exec_unit (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instr_word,
  input  wire logic [15:0] next_word,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        extended_set_enable_bit,
  input  wire logic [7:0]  table_latch_byte,
  output logic      [11:0] reg_addr,
  output logic             reg_we,
  output logic      [7:0]  reg_wdata,
  output logic      [7:0]  acc,
  output logic             flag_n,
  output logic             flag_z,
  output logic             instr_done,
  output logic             flush,
  output logic             ret_req,
  output logic      [11:0] third_pointer_register,
  output logic      [21:0] table_pointer,
  output logic      [7:0]  hold_rdata
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [3:0] bank,
                                           input logic xen, input logic [11:0] p2);
    logic [7:0] f;
    f = w[7:0];
    if (w[`TSXE_BIT_A]) begin
      eff_addr = {bank, f};
    end else if (xen && f <= `TSXE_ILO_LIMIT) begin
      eff_addr = p2 + {4'h0, f};
    end else begin
      eff_addr = (f[7]) ? {4'hf, f} : {4'h0, f};
    end
  endfunction : eff_addr

  logic is_tst, is_xorl, is_xorf, is_ext, is_ptr, is_twrite;
  assign is_tst   = instr_word[15:9] == `TSXE_OP_TST;
  assign is_xorl  = instr_word[15:8] == `TSXE_OP_XORL;
  assign is_xorf  = instr_word[15:10] == `TSXE_OP_XORF;
  assign is_ext   = extended_set_enable_bit && instr_word[15:12] == `TSXE_OP_EXT_HI;
  assign is_ptr   = is_ext && (instr_word[11:8] == `TSXE_OP_ADDP
                            || instr_word[11:8] == `TSXE_OP_SUBP);
  assign is_twrite = instr_word[15:2] == `TSXE_OP_TWRITE;

  // --------------------------------------------------------------------
  // Phase and state
  // --------------------------------------------------------------------
  tsxe_pkg::tsxe_phase_t phase_q, phase_d;
  tsxe_pkg::tsxe_state_t state_q, state_d;
  logic [7:0]  acc_d;
  logic        n_d, z_d;
  logic [11:0] p2_d;
  logic [21:0] tp_d;
  logic        hold_we;
  logic [7:0]  xres;
  logic        skip, two_word, ret_p2;
  logic        pre_pend_q, pre_pend_d;

  assign reg_addr = eff_addr(instr_word, bank_select_register, extended_set_enable_bit,
                             third_pointer_register);
  assign xres     = acc ^ (is_xorl ? instr_word[7:0] : reg_rdata);
  assign skip     = is_tst && reg_rdata == 8'h00;
  assign two_word = next_word[15:12] == `TSXE_OP_EXT_HI
                 || next_word[15:12] == 4'hc || next_word[15:12] == 4'hf;
  assign ret_p2   = is_ptr && instr_word[7:6] == `TSXE_PTR_RET;
  assign flush    = state_q != tsxe_pkg::TSXE_EXEC;
  assign instr_done = phase_q == tsxe_pkg::TSXE_Q4 && state_q == tsxe_pkg::TSXE_EXEC
                   && !skip && !ret_p2;

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      tsxe_pkg::TSXE_Q1: phase_d = tsxe_pkg::TSXE_Q2;
      tsxe_pkg::TSXE_Q2: phase_d = tsxe_pkg::TSXE_Q3;
      tsxe_pkg::TSXE_Q3: phase_d = tsxe_pkg::TSXE_Q4;
      tsxe_pkg::TSXE_Q4: phase_d = tsxe_pkg::TSXE_Q1;
    endcase
  end

  always_comb begin
    state_d   = state_q;
    acc_d     = acc;
    n_d       = flag_n;
    z_d       = flag_z;
    p2_d      = third_pointer_register;
    tp_d      = table_pointer;
    reg_we    = 1'b0;
    reg_wdata = xres;
    hold_we   = 1'b0;
    ret_req   = 1'b0;
    if (phase_q == tsxe_pkg::TSXE_Q4) begin
      unique case (state_q)
        tsxe_pkg::TSXE_EXEC: begin
          if (skip) begin
            state_d = two_word ? tsxe_pkg::TSXE_FLUSH2 : tsxe_pkg::TSXE_FLUSH;
          end else if (is_xorl || is_xorf) begin
            n_d = xres[7];
            z_d = xres == 8'h00;
            if (is_xorf && instr_word[`TSXE_BIT_D]) begin
              reg_we = 1'b1;
            end else begin
              acc_d = xres;
            end
          end else if (ret_p2) begin
            p2_d = (instr_word[11:8] == `TSXE_OP_ADDP)
                 ? third_pointer_register + {6'h00, instr_word[5:0]}
                 : third_pointer_register - {6'h00, instr_word[5:0]};
            ret_req = 1'b1;
            state_d = tsxe_pkg::TSXE_FLUSH;
          end else if (is_ptr && instr_word[7:6] == `TSXE_PTR_SEL2) begin
            p2_d = (instr_word[11:8] == `TSXE_OP_ADDP)
                 ? third_pointer_register + {6'h00, instr_word[5:0]}
                 : third_pointer_register - {6'h00, instr_word[5:0]};
          end else if (is_twrite) begin
            if (instr_word[1:0] == 2'h3) begin
              tp_d = table_pointer + 22'h1;
            end else begin
              hold_we = 1'b1;
              if (instr_word[1:0] == 2'h1) tp_d = table_pointer + 22'h1;
              if (instr_word[1:0] == 2'h2) tp_d = table_pointer - 22'h1;
            end
          end
        end
        tsxe_pkg::TSXE_FLUSH:  state_d = tsxe_pkg::TSXE_EXEC;
        tsxe_pkg::TSXE_FLUSH2: state_d = tsxe_pkg::TSXE_FLUSH;
        default:               state_d = tsxe_pkg::TSXE_EXEC;
      endcase
    end else if (phase_q == tsxe_pkg::TSXE_Q1 && pre_pend_q) begin
      // Next op already stands in the word here, so only the flag is trusted
      hold_we = 1'b1;
    end
  end

  // Pre-increment store happens on the following Q1, after the bump
  assign pre_pend_d = phase_q == tsxe_pkg::TSXE_Q4 && is_twrite && instr_word[1:0] == 2'h3
                   && state_q == tsxe_pkg::TSXE_EXEC;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q                <= tsxe_pkg::TSXE_Q1;
      state_q                <= tsxe_pkg::TSXE_EXEC;
      acc                    <= `TSXE_RST_ACC;
      flag_n                 <= 1'b0;
      flag_z                 <= 1'b0;
      third_pointer_register <= `TSXE_RST_FPTR;
      table_pointer          <= `TSXE_RST_PTR;
      pre_pend_q             <= 1'b0;
    end else begin
      phase_q                <= phase_d;
      state_q                <= state_d;
      acc                    <= acc_d;
      flag_n                 <= n_d;
      flag_z                 <= z_d;
      third_pointer_register <= p2_d;
      table_pointer          <= tp_d;
      pre_pend_q             <= pre_pend_d;
    end
  end

  tsxe_hold_mem u_hold (
    .core_clk (core_clk),
    .we       (hold_we),
    .addr     (table_pointer[5:0]),
    .wdata    (table_latch_byte),
    .rdata    (hold_rdata)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_skip_q4;
    phase_q == tsxe_pkg::TSXE_Q4 && state_q == tsxe_pkg::TSXE_EXEC && skip;
  endsequence

  a_skip_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_skip_q4 |=> flush [*4])
    else $error("skip did not flush a whole cycle");
  a_tst_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_tst && state_q == tsxe_pkg::TSXE_EXEC) |=> $stable(flag_z) && $stable(flag_n))
    else $error("test instruction changed flags");
  a_skip_two_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_skip_q4 and two_word) |=> flush [*8])
    else $error("two-word skip too short");
  a_xor_zflag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase_q == tsxe_pkg::TSXE_Q4 && !flush && is_xorl) |=> flag_z == (acc == 8'h00))
    else $error("zero flag wrong after literal xor");
  a_xor_dest: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase_q == tsxe_pkg::TSXE_Q4 && !flush && is_xorf && instr_word[9]) |-> reg_we)
    else $error("register xor did not write back");
  a_bank_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    instr_word[8] |-> reg_addr[11:8] == bank_select_register)
    else $error("bank select not used");
  a_ext_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !extended_set_enable_bit |-> !ret_req)
    else $error("extended op ran while disabled");
  a_ret_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
    ret_req |=> flush [*4])
    else $error("return did not take a second cycle");
endmodule : tsxe_exec_unit

// File: src/tsxe_map.svh
// Purpose: Constants for the test/skip/xor execute unit
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   Encodings are matched on the upper bits of the word
`ifndef TSXE_MAP_SVH
`define TSXE_MAP_SVH

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
`define TSXE_OP_TST       7'h33
`define TSXE_OP_XORL      8'h0a
`define TSXE_OP_XORF      6'h06
`define TSXE_OP_EXT_HI    4'he
`define TSXE_OP_ADDP      4'h8
`define TSXE_OP_SUBP      4'h9
`define TSXE_OP_TWRITE    14'h0003
`define TSXE_OP_SECOND    4'hf

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TSXE_BIT_A        8
`define TSXE_BIT_D        9
`define TSXE_ILO_LIMIT    8'h5f
// Selector 2 adjusts the third pointer; 3 adjusts it and returns
`define TSXE_PTR_SEL2     2'h2
`define TSXE_PTR_RET      2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TSXE_RST_ACC      8'h00
`define TSXE_RST_PTR      22'h000000
`define TSXE_RST_FPTR     12'h000

`endif

// File: src/tsxe_pkg.sv
// Purpose: Types for the test/skip/xor execute unit
// Assumes: Nothing beyond the map header
// Notes:   Phase and state codes are one-hot
package tsxe_pkg;

  // --------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    TSXE_Q1 = 4'h1,
    TSXE_Q2 = 4'h2,
    TSXE_Q3 = 4'h4,
    TSXE_Q4 = 4'h8
  } tsxe_phase_t;

  // --------------------------------------------------------------------
  // Execution state
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    TSXE_EXEC  = 3'h1,
    TSXE_FLUSH = 3'h2,
    TSXE_FLUSH2 = 3'h4
  } tsxe_state_t;

endpackage : tsxe_pkg

// File: src/tsxe_hold_mem.sv
// Purpose: Write holding memory for the table write path
// Assumes: 64 byte entries indexed by the low pointer bits
// Notes:   Read data is registered
module tsxe_hold_mem (
  input  wire logic       core_clk,
  input  wire logic       we,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [64];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : tsxe_hold_mem

// File: verif/tsxe_regfile_model.sv
// Purpose: Banked data register file facing the execute unit
// Assumes: Flat twelve-bit address, read is combinational
// Notes:   The bench preloads cells through the array by hierarchy
module tsxe_regfile_model (
  input  wire logic        core_clk,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_we,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  assign reg_rdata = mem[reg_addr];
  always @(posedge core_clk) begin
    if (reg_we === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
    end
  end
endmodule : tsxe_regfile_model

// File: verif/tb.sv
// Purpose: Self-checking bench for the test/skip/xor execute unit
// Assumes: Each op owns twelve cycles; spare slots run as no-ops
// Notes:   Skip length is measured by counting idle cycles
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst_n, ext_en, instr_done, flush, ret_req, flag_n, flag_z, reg_we;
  logic [15:0] instr_word, next_word;
  logic [7:0]  reg_rdata, reg_wdata, acc, table_latch_byte, k, v, s_acc, hold_rdata, m_res;
  logic [3:0]  bank_select_register;
  logic [11:0] reg_addr, third_pointer_register, s_p2;
  logic [21:0] table_pointer, s_tp;
  logic        dn, rq, s_n, s_z;
  logic [31:0] rng;
  int          error_cnt, compares, fl, m_acc;

  tsxe_exec_unit uut (.core_clk(core_clk), .rst_n(rst_n), .instr_word(instr_word),
    .next_word(next_word), .reg_rdata(reg_rdata), .bank_select_register(bank_select_register),
    .extended_set_enable_bit(ext_en), .table_latch_byte(table_latch_byte),
    .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata), .acc(acc),
    .flag_n(flag_n), .flag_z(flag_z), .instr_done(instr_done), .flush(flush),
    .ret_req(ret_req), .third_pointer_register(third_pointer_register),
    .table_pointer(table_pointer), .hold_rdata(hold_rdata));
  tsxe_regfile_model p (.core_clk(core_clk), .reg_addr(reg_addr), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // One op: four phases, then eight cycles where skips show as idle
  // ----------------------------------------------------------------------
  task automatic run(input logic [15:0] w, input logic [15:0] nw);
    instr_word <= w;
    next_word  <= nw;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    dn = instr_done;
    rq = ret_req;
    @(posedge core_clk);
    instr_word <= 16'h0000;
    fl = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      if (i == 0) {s_acc, s_n, s_z, s_p2, s_tp} = {acc, flag_n, flag_z, third_pointer_register,
                                                   table_pointer};
      fl += int'(flush === 1'b1);
    end
    @(posedge core_clk);
  endtask : run

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    repeat (1000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    error_cnt = 0; compares = 0; rng = 32'h5abb; m_acc = 0;
    rst_n = 1'b0; instr_word = 16'h0000; next_word = 16'h0000; ext_en = 1'b0;
    bank_select_register = 4'h0; table_latch_byte = 8'h00;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rng = xs(rng);
      k = (i == 4) ? m_acc[7:0] : rng[7:0];
      run({8'h0a, k}, 16'h0000);
      m_acc = m_acc ^ int'(k);
      chk("acc", 32'(s_acc), 32'(m_acc));
      chk("nz", 32'({s_n, s_z}), 32'({m_acc[7], m_acc == 0}));
    end
    // Access bank upper half maps to bank f
    rng = xs(rng); v = rng[15:8]; p.mem[12'hf85] = v;
    run(16'h1885, 16'h0000);
    m_acc = m_acc ^ int'(v);
    chk("acc", 32'(s_acc), 32'(m_acc));
    chk("nz", 32'({s_n, s_z}), 32'({m_acc[7], m_acc == 0}));
    bank_select_register <= 4'h3;
    rng = xs(rng); v = rng[7:0]; p.mem[12'h322] = v;
    run(16'h1b22, 16'h0000);
    m_res = v ^ m_acc[7:0];
    chk("reg", 32'(p.mem[12'h322]), 32'(m_res));
    chk("nz", 32'({s_n, s_z}), 32'({m_res[7], m_res == 8'h00}));
    chk("acc", 32'(s_acc), 32'(m_acc));
    p.mem[12'h040] = 8'h01;
    run(16'h6640, 16'h1234);
    chk("done", 32'(dn), 32'h1);
    chk("idle", 32'(fl), 32'h0);
    p.mem[12'h040] = 8'h00;
    run(16'h6640, 16'h1234);
    chk("idle", 32'(fl), 32'h4);
    chk("nz", 32'({s_n, s_z}), 32'({m_res[7], m_res == 8'h00}));
    run(16'h6640, 16'hc000);
    chk("idle", 32'(fl), 32'h8);
    run(16'he8a3, 16'h0000);
    chk("ptr2", 32'(s_p2), 32'h0);
    ext_en <= 1'b1;
    run(16'he8a3, 16'h0000);
    chk("ptr2", 32'(s_p2), 32'h23);
    // Low offsets now index from the third pointer
    rng = xs(rng); v = rng[7:0]; p.mem[12'h033] = v; p.mem[12'h010] = ~v;
    run(16'h1810, 16'h0000);
    m_acc = m_acc ^ int'(v);
    chk("acc", 32'(s_acc), 32'(m_acc));
    run(16'he8c5, 16'h0000);
    chk("ret", 32'(rq), 32'h1);
    chk("ptr2", 32'(s_p2), 32'h28);
    table_latch_byte <= rng[23:16];
    run(16'h000d, 16'h0000);
    chk("tptr", 32'(s_tp), 32'h1);
    chk("hold0", 32'(uut.u_hold.mem[0]), 32'(rng[23:16]));
    run(16'h000f, 16'h0000);
    chk("tptr", 32'(s_tp), 32'h2);
    @(negedge core_clk);
    chk("hold", 32'(hold_rdata), 32'(rng[23:16]));
    conclude();
  end
endmodule : tb
